// file: design/mwp_window_regs.sv
// Host-facing 8KB window decode with paged boot-RAM download registers.
// Assumes a synchronous host bus model: one rd or wr strobe per cycle,
// and a boot RAM / flash engine that reports its own page links.
// Limitation: Deep Power-Down is only a mode code here; the exit
// sequence and the gating of the bus in that mode live elsewhere,
// as do the registers that this bank only decodes.
`timescale 1ns/10ps
`include "mwp_defs.svh"

module mwp_window_regs #(
	parameter logic [15:0] IDENT_LOW = 16'h1234, // Arbitrary value.
	parameter logic [15:0] IDENT_HIGH = 16'hedcb, // Arbitrary value.
	parameter int LOAD_CYCLES = `MWP_LOAD_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic clockEnable,
	// Host bus
	input wire mwp_pkg::mwp_bus_s hostBus,
	output logic [15:0] readData,
	// Boot block and boot RAM side
	input wire logic [15:0] bootData,
	input wire logic [6:0] linkNextPage,
	output logic ramLoadStart,
	output logic [6:0] ramLoadPage,
	output logic ramLoadSerial,
	// Status
	output logic [1:0] opMode,
	output logic loadReady
);

	mwp_pkg::mwp_state_s s_q, s_d;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------

	function automatic logic isBoot(input logic [12:0] a);
		logic [1:0] sect;
		sect = a[`MWP_SECT_LSB +: `MWP_SECT_BITS];
		return (sect == 2'd0) || (sect == 2'd3);
	endfunction

	// Bit 0 only picks a byte lane, so registers decode on even offsets.
	function automatic logic [12:0] regOff(input logic [12:0] a);
		return {a[12:1], 1'b0};
	endfunction

	function automatic logic hit(input logic [12:0] a,
		input logic [12:0] off);
		return regOff(a) == off;
	endfunction

	// Conditions shared by the read and write paths.
	logic inReset;
	logic [7:0] wByte;
	logic loadBusy;
	assign inReset = s_q.control[1:0] == `MWP_MODE_RESET;
	assign wByte = hostBus.wdata[7:0];
	assign loadBusy = !s_q.loadIdle;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------

	always_comb begin
		logic [15:0] rv;
		logic [7:0] wc;
		rv = 16'h0000;
		wc = 8'h00;
		s_d = s_q;
		s_d.ramStart = 1'b0;

		// ----------------------------------------------------------
		// Read path
		// ----------------------------------------------------------

		// Boot block reads pass in every mode; the host may be
		// executing from it while the registers are still held at zero.
		if (hostBus.rd) begin
			if (isBoot(hostBus.addr)) begin
				rv = bootData;
			end else if (inReset) begin
				rv = 16'h0000;
			end else begin
				unique case (regOff(hostBus.addr))
					`MWP_OFF_IDENT_LOW: rv = IDENT_LOW;
					`MWP_OFF_IDENT_HIGH: rv = IDENT_HIGH;
					// Mode write enable always reads 0; bits 7-5 read 0.
					`MWP_OFF_CONTROL: rv = {8'h00, 3'b000,
						s_q.control[4:3], 1'b0, s_q.control[1:0]};
					`MWP_OFF_RAM_STATUS: rv = {8'h00, 7'h00, !loadBusy};
					`MWP_OFF_DMA_CTRL0: rv = s_q.dmaCtrl0;
					`MWP_OFF_DMA_CTRL1: rv = s_q.dmaCtrl1;
					// Decoded here but kept by other blocks, so they read 0
					// from this bank; write-only slots read 0 as well.
					`MWP_OFF_TEST,
					`MWP_OFF_BYTE_ORDER,
					`MWP_OFF_DEV_SELECT,
					`MWP_OFF_CONFIG,
					`MWP_OFF_IRQ_CTRL,
					`MWP_OFF_OUT_CTRL,
					`MWP_OFF_BURST,
					`MWP_OFF_IRQ_STATUS,
					`MWP_OFF_CONFIRM,
					`MWP_OFF_IDLE_DELAY,
					`MWP_OFF_PWR_DOWN: rv = 16'h0000;
					default: rv = 16'h0000;
				endcase
			end
			s_d.rdata = rv;
			// A non-boot read breaks the control pairing and the serial
			// arm, which only tolerates boot RAM reads; the page arm
			// only counts writes, so it survives any read.
			if (!isBoot(hostBus.addr)) begin
				s_d.pendValid = 1'b0;
				s_d.serialArm = 1'b0;
			end
		end

		// ----------------------------------------------------------
		// Write path: arm, page select and serial download
		// ----------------------------------------------------------

		if (hostBus.wr) begin
			// Arming lasts only until the next write, whatever it hits.
			s_d.armed = 1'b0;
			s_d.serialArm = 1'b0;
			s_d.pendValid = 1'b0;
			if (hit(hostBus.addr, `MWP_OFF_ARM_CMD)) begin
				// Reserved command values simply leave both arms clear.
				s_d.armed = wByte == `MWP_ARM_VALUE;
				s_d.serialArm = wByte == `MWP_ARM_VALUE;
			end else if (hit(hostBus.addr, `MWP_OFF_PAGE_SEL)) begin
				if (s_q.armed && !loadBusy) begin
					s_d.load = mwp_pkg::MWP_PAGE;
					s_d.loadCnt = 16'(LOAD_CYCLES);
					if (wByte[`MWP_FOLLOW_BIT]) begin
						s_d.loadPage = s_q.nextPage;
					end else begin
						s_d.loadPage = wByte[6:0];
					end
					s_d.ramStart = 1'b1;
					s_d.ramPage = s_d.loadPage;
					s_d.ramSerial = 1'b0;
				end
			end else if (hit(hostBus.addr, `MWP_OFF_SERIAL_LOAD)) begin
				// A download asked for while one runs is dropped; the
				// host is expected to poll ready before the next one.
				if (s_q.serialArm && !loadBusy) begin
					s_d.load = mwp_pkg::MWP_SERIAL;
					s_d.loadCnt = 16'(LOAD_CYCLES);
					s_d.ramStart = 1'b1;
					s_d.ramSerial = 1'b1;
				end
			// ------------------------------------------------------
			// Control pairing
			// ------------------------------------------------------
			end else if (hit(hostBus.addr, `MWP_OFF_CONTROL)) begin
				// First half of the pairing; nothing applies until the
				// complement arrives at the confirmation slot.
				s_d.pendCtrl = wByte;
				s_d.pendValid = 1'b1;
			end else if (hit(hostBus.addr, `MWP_OFF_CONFIRM)) begin
				wc = s_q.pendCtrl;
				if (s_q.pendValid && wByte == ~wc) begin
					// Code 11 is not a mode; taking it would leave the
					// bank in a state that no decode path expects.
					if (wc[`MWP_CTRL_WREN_BIT] && (wc[1:0] inside
						{`MWP_MODE_RESET, `MWP_MODE_NORMAL,
						`MWP_MODE_DPD})) begin
						s_d.control[1:0] = wc[1:0];
						if (inReset && wc[1:0] == `MWP_MODE_NORMAL) begin
							s_d.dmaCtrl0 = 16'h0000;
							s_d.dmaCtrl1 = 16'h0000;
						end
					end
					// Status flags clear on writing a one.
					if (wc[`MWP_CTRL_BDET_BIT]) begin
						s_d.control[`MWP_CTRL_BDET_BIT] = 1'b0;
					end
					if (wc[`MWP_CTRL_RSTLAT_BIT]) begin
						s_d.control[`MWP_CTRL_RSTLAT_BIT] = 1'b0;
					end
				end
			end else if (!inReset) begin
				// Only the DMA pair is stored here; the delay slot and
				// the slots kept by other blocks leave this bank alone.
				if (hit(hostBus.addr, `MWP_OFF_DMA_CTRL0)) begin
					s_d.dmaCtrl0 = hostBus.wdata;
				end else if (hit(hostBus.addr, `MWP_OFF_DMA_CTRL1)) begin
					s_d.dmaCtrl1 = hostBus.wdata;
				end else if (hit(hostBus.addr, `MWP_OFF_IDLE_DELAY)) begin
					// A delay cycle: it ends the arm and the pairing
					// above and changes nothing else.
					s_d.pendValid = 1'b0;
				end
			end
			// Boot block writes during pairing would be other cycles too.
		end

		// ----------------------------------------------------------
		// Download timer
		// ----------------------------------------------------------

		// The page link is taken when a page lands, so a follow-link
		// request always sees the page that finished last.
		if (loadBusy && !s_d.ramStart) begin
			if (s_q.loadCnt <= 16'd1) begin
				if (s_q.load == mwp_pkg::MWP_PAGE) begin
					s_d.curPage = s_q.loadPage;
					s_d.nextPage = linkNextPage;
				end
				s_d.load = mwp_pkg::MWP_IDLE;
				s_d.loadCnt = 16'h0000;
			end else begin
				s_d.loadCnt = s_q.loadCnt - 16'd1;
			end
		end

		// ----------------------------------------------------------
		// Ready flag
		// ----------------------------------------------------------

		// Registered, so the ready output comes straight off a flop
		// and polls of it see the same value as the status register.
		s_d.loadIdle = s_d.load == mwp_pkg::MWP_IDLE;
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------

	// Clock enable low freezes everything, the download timer included,
	// so a stalled host bus cannot lose or shorten a pending load.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			// Field by field, so that the reset values stay visible;
			// a field added to the state must be added here as well.
			s_q.control <= `MWP_CTRL_RESET;
			s_q.armed <= 1'b0;
			s_q.serialArm <= 1'b0;
			s_q.curPage <= 7'h00;
			s_q.nextPage <= 7'h00;
			s_q.loadPage <= 7'h00;
			s_q.load <= mwp_pkg::MWP_IDLE;
			s_q.loadCnt <= 16'h0000;
			s_q.dmaCtrl0 <= 16'h0000;
			s_q.dmaCtrl1 <= 16'h0000;
			s_q.pendCtrl <= 8'h00;
			s_q.pendValid <= 1'b0;
			s_q.rdata <= 16'h0000;
			s_q.ramStart <= 1'b0;
			s_q.ramPage <= 7'h00;
			s_q.ramSerial <= 1'b0;
			s_q.loadIdle <= 1'b1;
		end else if (clockEnable) begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------

	// Every output is a field of the state register, never logic, so
	// the host side sees no glitch from the decode above.
	assign readData = s_q.rdata;
	assign ramLoadStart = s_q.ramStart;
	assign ramLoadPage = s_q.ramPage;
	assign ramLoadSerial = s_q.ramSerial;
	assign opMode = s_q.control[1:0];
	assign loadReady = s_q.loadIdle;

endmodule

// file: include/mwp_defs.svh
// Offsets, fields, reset values and timing counts of the memory window.
// Assumes byte offsets relative to the window base on a 13-bit address.
`ifndef MWP_DEFS_SVH
`define MWP_DEFS_SVH
`define MWP_SECT_BITS 2
`define MWP_SECT_LSB 11
`define MWP_OFF_ARM_CMD 13'h0030
`define MWP_OFF_PAGE_SEL 13'h0070
`define MWP_OFF_SERIAL_LOAD 13'h0080
`define MWP_OFF_IDENT_LOW 13'h1000
`define MWP_OFF_IDLE_DELAY 13'h103e
`define MWP_OFF_IDENT_HIGH 13'h1074
`define MWP_OFF_CONTROL 13'h100c
`define MWP_OFF_CONFIRM 13'h1072
`define MWP_OFF_DMA_CTRL0 13'h1078
`define MWP_OFF_DMA_CTRL1 13'h107a
`define MWP_OFF_RAM_STATUS 13'h1024
`define MWP_OFF_TEST 13'h1004
`define MWP_OFF_BYTE_ORDER 13'h1008
`define MWP_OFF_DEV_SELECT 13'h100a
`define MWP_OFF_CONFIG 13'h100e
`define MWP_OFF_IRQ_CTRL 13'h1010
`define MWP_OFF_OUT_CTRL 13'h1014
`define MWP_OFF_BURST 13'h101c
`define MWP_OFF_IRQ_STATUS 13'h1020
`define MWP_OFF_PWR_DOWN 13'h107c
`define MWP_ARM_VALUE 8'h71
`define MWP_FOLLOW_BIT 7
`define MWP_MODE_RESET 2'b00
`define MWP_MODE_NORMAL 2'b01
`define MWP_MODE_DPD 2'b10
`define MWP_CTRL_RESET 8'h10
`define MWP_CTRL_WREN_BIT 2
`define MWP_CTRL_BDET_BIT 3
`define MWP_CTRL_RSTLAT_BIT 4
`define MWP_SERIAL_BYTES 16
`define MWP_LOAD_NS 1000
`define MWP_CLK_NS 10
`define MWP_LOAD_CYCLES ((`MWP_LOAD_NS + `MWP_CLK_NS - 1) / `MWP_CLK_NS)
`endif

// file: include/mwp_pkg.sv
// Types shared by the memory window block.
// Assumes mwp_defs.svh is not needed here; types only.
package mwp_pkg;
	typedef enum logic [1:0] {MWP_IDLE, MWP_PAGE, MWP_SERIAL} mwp_load_e;
	typedef struct packed {
		logic rd;
		logic wr;
		logic [12:0] addr;
		logic [15:0] wdata;
	} mwp_bus_s;
	typedef struct packed {
		logic [7:0] control;
		logic armed;
		logic serialArm;
		logic [6:0] curPage;
		logic [6:0] nextPage;
		logic [6:0] loadPage;
		mwp_load_e load;
		logic [15:0] loadCnt;
		logic [15:0] dmaCtrl0;
		logic [15:0] dmaCtrl1;
		logic [7:0] pendCtrl;
		logic pendValid;
		logic [15:0] rdata;
		logic ramStart;
		logic [6:0] ramPage;
		logic ramSerial;
		logic loadIdle;
	} mwp_state_s;
endpackage

// file: test/mwp_window_monitor.sv
// Port checker for the memory window register bank.
// Assumes it is bound to mwp_window_regs.
`timescale 1ns/10ps
module mwp_window_monitor #(
	parameter logic [15:0] IDENT_LOW = 16'h0,
	parameter logic [15:0] IDENT_HIGH = 16'h0
) (
	// Watched ports
	input wire logic clock,
	input wire logic rst,
	input wire logic clockEnable,
	input wire mwp_pkg::mwp_bus_s hostBus,
	input wire logic [15:0] readData,
	input wire logic [15:0] bootData,
	input wire logic ramLoadStart,
	input wire logic [6:0] ramLoadPage,
	input wire logic ramLoadSerial,
	input wire logic [1:0] opMode,
	input wire logic loadReady
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wire logic rd = clockEnable && hostBus.rd;
	wire logic wr = clockEnable && hostBus.wr;
	wire logic [12:0] a = hostBus.addr;
	wire logic arm = wr && a == 13'h0030 && hostBus.wdata[7:0] == 8'h71;
	property p_rdz;
		rd && opMode == 2'b00 && a[12:11] inside {2'd1, 2'd2} |=> readData == 0;
	endproperty
	a_rdz: assert property (p_rdz) else $error("zero read");
	property p_id;
		rd && opMode == 2'b01 && a == 13'h1000 |=> readData == IDENT_LOW;
	endproperty
	a_id: assert property (p_id) else $error("ident read");
	property p_boot;
		rd && a[12:11] inside {2'd0, 2'd3} |=> readData == $past(bootData);
	endproperty
	a_boot: assert property (p_boot) else $error("boot read");
	property p_arm;
		arm ##1 (wr && a == 13'h0070 && !hostBus.wdata[7] && loadReady)
		|=> ramLoadStart && ramLoadPage == $past(hostBus.wdata[6:0]);
	endproperty
	a_arm: assert property (p_arm) else $error("page load");
	property p_noarm;
		wr && a == 13'h0070 && $past(wr) && $past(a) != 13'h0030
		|=> !ramLoadStart;
	endproperty
	a_noarm: assert property (p_noarm) else $error("unarmed load");
	property p_ser;
		arm ##1 (wr && a == 13'h0080 && loadReady)
		|=> ramLoadStart && ramLoadSerial;
	endproperty
	a_ser: assert property (p_ser) else $error("serial load");
	property p_busy;
		$rose(ramLoadStart) |-> !loadReady ##[1:8] loadReady;
	endproperty
	a_busy: assert property (p_busy) else $error("ready");
	property p_mode;
		opMode != 2'b11;
	endproperty
	a_mode: assert property (p_mode) else $error("mode code");
endmodule

// file: test/mwp_flash_model.sv
// Boot block and flash engine stand-in for the memory window.
// Assumes one load at a time, started by a one-cycle pulse.
`timescale 1ns/10ps
module mwp_flash_model (
	// Window side
	input wire logic clock,
	input wire logic rst,
	input wire logic [12:0] addr,
	input wire logic ramLoadStart,
	input wire logic [6:0] ramLoadPage,
	output logic [15:0] bootData,
	output logic [6:0] linkNextPage
);
	// Low address bits only, so both mirrors show the same block.
	assign bootData = {5'h15, addr[10:0]};
	always_ff @(posedge clock or posedge rst) begin
		if (rst) linkNextPage <= 7'h0;
		else if (ramLoadStart) linkNextPage <= ramLoadPage + 7'h1;
	end
endmodule

// file: test/tb.sv
// Self-checking bench for the memory window register bank.
// Assumes the flash model answers loads and feeds boot data.
`timescale 1ns/10ps
module tb;
	localparam logic [15:0] ID_LO = 16'h5a3c; // Arbitrary value.
	localparam logic [15:0] ID_HI = 16'hc3a5; // Arbitrary value.
	logic clock = 1'b0;
	logic rst = 1'b1;
	mwp_pkg::mwp_bus_s hostBus = '0;
	logic [15:0] readData, bootData;
	logic [6:0] linkNextPage, ramLoadPage;
	logic ramLoadStart, ramLoadSerial, loadReady;
	logic [1:0] opMode;
	int miscompares = 0;
	int n_checks = 0;
	int cycles = 0;
	mwp_window_regs #(.IDENT_LOW(ID_LO), .IDENT_HIGH(ID_HI), .LOAD_CYCLES(3))
	DUT (.clock(clock), .rst(rst), .clockEnable(1'b1), .hostBus(hostBus),
		.readData(readData), .bootData(bootData), .linkNextPage(linkNextPage),
		.ramLoadStart(ramLoadStart), .ramLoadPage(ramLoadPage),
		.ramLoadSerial(ramLoadSerial), .opMode(opMode), .loadReady(loadReady));
	mwp_flash_model flash (.clock(clock), .rst(rst), .addr(hostBus.addr),
		.ramLoadStart(ramLoadStart), .ramLoadPage(ramLoadPage),
		.bootData(bootData), .linkNextPage(linkNextPage));
	initial forever #5 clock = ~clock;
	task finish_test;
		if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			finish_test;
		end
	end
	task chk(input string s, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	// One access a cycle, set at a falling edge and held until the next.
	task acc(input logic r, input logic [12:0] a, input logic [15:0] d);
		hostBus = '{rd: r, wr: ~r, addr: a, wdata: d};
		@(negedge clock);
	endtask
	task rdc(input logic [12:0] a, input logic [15:0] e);
		acc(1'b1, a, 16'h0);
		chk("readData", e, readData);
	endtask
	task wready;
		for (int i = 0; i < 20 && loadReady !== 1'b1; i++)
			rdc(13'h0, 16'ha800);
		chk("loadReady", 16'h1, {15'h0, loadReady});
	endtask
	initial begin
		repeat (20) @(negedge clock);
		rst = 1'b0;
		rdc(13'h1000, 16'h0);
		rdc(13'h0900, 16'h0);
		rdc(13'h0004, 16'ha804);
		rdc(13'h1804, 16'ha804);
		acc(1'b0, 13'h0030, 16'h0071);
		acc(1'b0, 13'h0070, 16'h0005);
		chk("ramLoadStart", 16'h1, {15'h0, ramLoadStart});
		chk("ramLoadPage", 16'h5, {9'h0, ramLoadPage});
		wready;
		acc(1'b0, 13'h0070, 16'h0006);
		chk("ramLoadStart", 16'h0, {15'h0, ramLoadStart});
		acc(1'b0, 13'h0030, 16'h0071);
		acc(1'b0, 13'h0070, 16'h0083);
		chk("ramLoadPage", 16'h6, {9'h0, ramLoadPage});
		wready;
		acc(1'b0, 13'h0030, 16'h0071);
		rdc(13'h0002, 16'ha802);
		acc(1'b0, 13'h0080, 16'h0000);
		chk("ramLoadSerial", 16'h1, {15'h0, ramLoadSerial});
		wready;
		acc(1'b0, 13'h1078, 16'h1111);
		acc(1'b0, 13'h100c, 16'h0005);
		acc(1'b0, 13'h1072, 16'h00fa);
		chk("opMode", 16'h1, {14'h0, opMode});
		rdc(13'h1078, 16'h0);
		rdc(13'h1000, ID_LO);
		rdc(13'h1074, ID_HI);
		acc(1'b0, 13'h107a, 16'habcd);
		acc(1'b0, 13'h103e, 16'hffff);
		rdc(13'h107a, 16'habcd);
		rdc(13'h1024, 16'h0001);
		rdc(13'h100c, 16'h0011);
		acc(1'b0, 13'h0030, 16'h0071);
		rdc(13'h1000, ID_LO);
		acc(1'b0, 13'h0080, 16'h0000);
		chk("ramLoadStart", 16'h0, {15'h0, ramLoadStart});
		acc(1'b0, 13'h100c, 16'h0007);
		acc(1'b0, 13'h1072, 16'h00f8);
		chk("opMode", 16'h1, {14'h0, opMode});
		finish_test;
	end
endmodule
bind mwp_window_regs mwp_window_monitor #(.IDENT_LOW(IDENT_LOW),
	.IDENT_HIGH(IDENT_HIGH)) mon (.clock(clock), .rst(rst),
	.clockEnable(clockEnable), .hostBus(hostBus), .readData(readData),
	.bootData(bootData), .ramLoadStart(ramLoadStart),
	.ramLoadPage(ramLoadPage), .ramLoadSerial(ramLoadSerial),
	.opMode(opMode), .loadReady(loadReady));
